// ==== src/vec_cfg_defines.vh ====
// Field positions, reset values, encodings and timing for the enhanced volatile configuration block
`ifndef VEC_CFG_DEFINES_VH
`define VEC_CFG_DEFINES_VH

// Register field positions
`define VEC_BIT_QUAD_N    7
`define VEC_BIT_DUAL_N    6
`define VEC_BIT_RSVD      5
`define VEC_BIT_HOLD_EN   4
`define VEC_BIT_ACC_N     3
`define VEC_DRV_MSB       2
`define VEC_DRV_LSB       0

// Reset value: extended protocol, hold on, accelerator off, 30 ohm code
`define VEC_RST_VALUE     8'hDF
// Writable bits; reserved bit 5 is held at zero
`define VEC_WR_MASK       8'hDF
`define VEC_ACC_DEFAULT   1'b1
`define VEC_DRV_RST       3'h7

// Reserved drive codes 000 and 100 share low bits 00
`define VEC_DRV_RSVD_LOW  2'h0

// Effective protocol encoding
`define VEC_PROTO_EXT     2'h0
`define VEC_PROTO_DUAL    2'h1
`define VEC_PROTO_QUAD    2'h2

// Bits moved per serial clock in each protocol
`define VEC_BPC_EXT       4'h1
`define VEC_BPC_DUAL      4'h2
`define VEC_BPC_QUAD      4'h4

// Data line enables while answering
`define VEC_OE_EXT        4'h2
`define VEC_OE_DUAL       4'h3
`define VEC_OE_QUAD       4'hF
`define VEC_OE_NONE       4'h0

// Flag status positions
`define VEC_FSR_READY     7
`define VEC_FSR_VPP_ERR   3

// Frame byte counts: opcode plus three address bytes, plus data for programs
`define VEC_ERASE_BYTES   3'h4
`define VEC_PROG_BYTES    3'h5
`define VEC_BYTE_CNT_MAX  3'h7

// Accelerator raise timeout
`define VEC_TMO_MS        200
`define VEC_CLK_KHZ       100000
`define VEC_TMO_CYC       (`VEC_TMO_MS * `VEC_CLK_KHZ)

`endif

// ==== src/vec_pin_sync.v ====
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`include "vec_cfg_defines.vh"

module vec_pin_sync #(
  parameter W = 7
) (
  // Clock and reset
  input  wire         core_clk_i,
  input  wire         rstn_i,
  // Asynchronous pins
  input  wire [W-1:0] pin_i,
  // Filtered level and edges
  output wire [W-1:0] lvl_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] filt_q;
  reg [W-1:0] rise_q;
  reg [W-1:0] fall_q;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      // First stage feeds only the second; the filter looks at stages two and three
      always @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          s1_q[g]   <= 1'b1;
          s2_q[g]   <= 1'b1;
          s3_q[g]   <= 1'b1;
          filt_q[g] <= 1'b1;
          rise_q[g] <= 1'b0;
          fall_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g]   <= pin_i[g];
          s2_q[g]   <= s1_q[g];
          s3_q[g]   <= s2_q[g];
          rise_q[g] <= 1'b0;
          fall_q[g] <= 1'b0;
          if ((s2_q[g] == s3_q[g]) && (s3_q[g] != filt_q[g]))
          begin
            filt_q[g] <= s3_q[g];
            rise_q[g] <= s3_q[g];
            fall_q[g] <= ~s3_q[g];
          end
        end
      end
    end
  endgenerate

  assign lvl_o  = filt_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule

// ==== src/vec_config_core.v ====
// Enhanced volatile configuration register with protocol, hold, accelerator and drive control
`timescale 1ns/1ps
`include "vec_cfg_defines.vh"

module vec_config_core #(
  parameter [7:0]  OP_WR_CFG     = 8'hA1,
  parameter [7:0]  OP_RD_CFG     = 8'hA5,
  parameter [7:0]  OP_RD_FLAG    = 8'hA7,
  parameter [7:0]  OP_CLR_FLAG   = 8'hA9,
  parameter [7:0]  OP_PAGE_PROG  = 8'hB2,
  parameter [7:0]  OP_QFP        = 8'hB3,
  parameter [7:0]  OP_QEFP       = 8'hB4,
  parameter [7:0]  OP_ERASE      = 8'hC0,
  parameter [7:0]  OP_SUSPEND    = 8'hC5,
  parameter [31:0] TIMEOUT_CYC   = `VEC_TMO_CYC
) (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rstn_i,
  // Serial bus pins
  input  wire       spi_clk_i,
  input  wire       cs_n_i,
  input  wire [3:0] dq_i,
  output wire [3:0] dq_o,
  output wire [3:0] dq_oe_o,
  // Accelerator level on data line two, high while raised
  input  wire       vpp_high_i,
  // Nonvolatile configuration bits
  input  wire       nv_quad_n_i,
  input  wire       nv_dual_n_i,
  input  wire       nv_hold_en_i,
  input  wire [2:0] nv_drive_i,
  // Configuration state
  output wire [7:0] cfg_o,
  output wire [1:0] protocol_o,
  output wire       hold_en_o,
  output wire [2:0] drive_code_o,
  output wire       drive_valid_o,
  output wire       acc_enable_o,
  output wire       temp_ext_o,
  output wire       vpp_err_o,
  // Modify operation control
  output wire       op_start_o,
  output wire       op_fast_o,
  output wire       suspend_o
);

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_WAIT_HI = 2'h1;
  localparam [1:0] ST_WAIT_LO = 2'h2;

  // Pin synchronisation: bit0 clock, bit1 select, bit2 accelerator, bits6:3 data
  wire [6:0] pin_lvl;
  wire [6:0] pin_rise;
  wire [6:0] pin_fall;

  vec_pin_sync #(
    .W (7)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pin_i      ({dq_i, vpp_high_i, cs_n_i, spi_clk_i}),
    .lvl_o      (pin_lvl),
    .rise_o     (pin_rise),
    .fall_o     (pin_fall)
  );

  wire [3:0] dq_lvl    = pin_lvl[6:3];
  wire       vpp_lvl   = pin_lvl[2];
  wire       cs_active = ~pin_lvl[1];
  wire       cs_rel    = pin_rise[1];

  reg  [7:0]  cfg_q;
  reg         load_q;
  reg  [1:0]  proto_q;
  reg         hold_en_q;
  reg  [2:0]  drive_q;
  reg         drive_valid_q;
  reg         acc_en_q;
  reg  [7:0]  rx_q;
  reg  [2:0]  bit_cnt_q;
  reg  [2:0]  byte_cnt_q;
  reg  [7:0]  opcode_q;
  reg  [7:0]  out_sr_q;
  reg         out_act_q;
  reg  [3:0]  dq_q;
  reg  [3:0]  dq_oe_q;
  reg  [1:0]  st_q;
  reg  [31:0] timer_q;
  reg         temp_ext_q;
  reg         vpp_err_q;
  reg         op_start_q;
  reg         op_fast_q;
  reg         suspend_q;

  // Hold is honoured only while enabled and data line three is not carrying quad data
  wire hold_pause = hold_en_q & (proto_q != `VEC_PROTO_QUAD) & ~dq_lvl[3];
  wire sck_rise   = pin_rise[0] & cs_active & ~hold_pause;
  wire sck_fall   = pin_fall[0] & cs_active & ~hold_pause;

  // Receive shift per protocol width
  reg [7:0] rx_d;
  reg [3:0] bpc;
  always @*
  begin
    case (proto_q)
      `VEC_PROTO_DUAL:
      begin
        rx_d = {rx_q[5:0], dq_lvl[1:0]};
        bpc  = `VEC_BPC_DUAL;
      end
      `VEC_PROTO_QUAD:
      begin
        rx_d = {rx_q[3:0], dq_lvl};
        bpc  = `VEC_BPC_QUAD;
      end
      default:
      begin
        rx_d = {rx_q[6:0], dq_lvl[0]};
        bpc  = `VEC_BPC_EXT;
      end
    endcase
  end

  wire [3:0] bit_sum   = {1'b0, bit_cnt_q} + bpc;
  wire       byte_done = bit_sum[3];

  // Effective protocol: temporary extended phase overrides, then quad over dual
  reg [1:0] proto_d;
  always @*
  begin
    if (temp_ext_q)
      proto_d = `VEC_PROTO_EXT;
    else if (!cfg_q[`VEC_BIT_QUAD_N])
      proto_d = `VEC_PROTO_QUAD;
    else if (!cfg_q[`VEC_BIT_DUAL_N])
      proto_d = `VEC_PROTO_DUAL;
    else
      proto_d = `VEC_PROTO_EXT;
  end

  // Frame classification at deselect
  wire is_prog_op = (opcode_q == OP_PAGE_PROG) | (opcode_q == OP_QFP) | (opcode_q == OP_QEFP);
  wire is_prog    = is_prog_op & (byte_cnt_q >= `VEC_PROG_BYTES);
  wire is_erase   = (opcode_q == OP_ERASE) & (byte_cnt_q >= `VEC_ERASE_BYTES);
  wire quad_mod   = (is_prog & ((opcode_q == OP_QFP) | (opcode_q == OP_QEFP)))
                  | ((proto_q == `VEC_PROTO_QUAD) & (is_prog | is_erase));

  wire [7:0] flag_val = {(st_q == ST_IDLE), 3'h0, vpp_err_q, 3'h0};

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_q         <= `VEC_RST_VALUE;
      load_q        <= 1'b1;
      proto_q       <= `VEC_PROTO_EXT;
      hold_en_q     <= 1'b1;
      drive_q       <= `VEC_DRV_RST;
      drive_valid_q <= 1'b1;
      acc_en_q      <= 1'b0;
      rx_q          <= 8'h00;
      bit_cnt_q     <= 3'h0;
      byte_cnt_q    <= 3'h0;
      opcode_q      <= 8'h00;
      out_sr_q      <= 8'h00;
      out_act_q     <= 1'b0;
      dq_q          <= 4'h0;
      dq_oe_q       <= `VEC_OE_NONE;
      st_q          <= ST_IDLE;
      timer_q       <= 32'h0;
      temp_ext_q    <= 1'b0;
      vpp_err_q     <= 1'b0;
      op_start_q    <= 1'b0;
      op_fast_q     <= 1'b0;
      suspend_q     <= 1'b0;
    end
    else
    begin
      op_start_q <= 1'b0;
      suspend_q  <= 1'b0;
      proto_q    <= proto_d;
      hold_en_q  <= cfg_q[`VEC_BIT_HOLD_EN];
      drive_q    <= cfg_q[`VEC_DRV_MSB:`VEC_DRV_LSB];
      // Reserved codes leave the impedance undefined; flag them to the pad logic
      drive_valid_q <= (cfg_q[`VEC_DRV_LSB+1:`VEC_DRV_LSB] != `VEC_DRV_RSVD_LOW);
      acc_en_q   <= ~cfg_q[`VEC_BIT_ACC_N];

      // Power-on load from the nonvolatile bits, one cycle after reset release
      if (load_q)
      begin
        cfg_q  <= {nv_quad_n_i, nv_dual_n_i, 1'b0, nv_hold_en_i, `VEC_ACC_DEFAULT, nv_drive_i};
        load_q <= 1'b0;
      end

      if (!cs_active)
      begin
        bit_cnt_q  <= 3'h0;
        byte_cnt_q <= 3'h0;
        out_act_q  <= 1'b0;
        dq_oe_q    <= `VEC_OE_NONE;
      end
      else
      begin
        if (sck_rise)
        begin
          rx_q      <= rx_d;
          bit_cnt_q <= bit_sum[2:0];
          if (byte_done)
          begin
            if (byte_cnt_q != `VEC_BYTE_CNT_MAX)
              byte_cnt_q <= byte_cnt_q + 3'h1;
            if (byte_cnt_q == 3'h0)
            begin
              opcode_q <= rx_d;
              // Status polling and suspend stay usable in the temporary extended phase
              if (rx_d == OP_RD_CFG)
              begin
                out_sr_q  <= cfg_q;
                out_act_q <= 1'b1;
              end
              if (rx_d == OP_RD_FLAG)
              begin
                out_sr_q  <= flag_val;
                out_act_q <= 1'b1;
              end
              if (rx_d == OP_SUSPEND)
                suspend_q <= 1'b1;
              if (rx_d == OP_CLR_FLAG)
                vpp_err_q <= 1'b0;
            end
            else if ((byte_cnt_q == 3'h1) && (opcode_q == OP_WR_CFG))
              cfg_q <= rx_d & `VEC_WR_MASK;
          end
        end
        // Answer bits change on the falling edge; the byte repeats while selected
        if (sck_fall && out_act_q)
        begin
          case (proto_q)
            `VEC_PROTO_DUAL:
            begin
              dq_q     <= {2'h0, out_sr_q[7:6]};
              dq_oe_q  <= `VEC_OE_DUAL;
              out_sr_q <= {out_sr_q[5:0], out_sr_q[7:6]};
            end
            `VEC_PROTO_QUAD:
            begin
              dq_q     <= out_sr_q[7:4];
              dq_oe_q  <= `VEC_OE_QUAD;
              out_sr_q <= {out_sr_q[3:0], out_sr_q[7:4]};
            end
            default:
            begin
              dq_q     <= {2'h0, out_sr_q[7], 1'b0};
              dq_oe_q  <= `VEC_OE_EXT;
              out_sr_q <= {out_sr_q[6:0], out_sr_q[7]};
            end
          endcase
        end
      end

      // Modify sequencing; a new frame while busy is not started
      case (st_q)
        ST_IDLE:
        begin
          if (cs_rel && (is_prog || is_erase))
          begin
            if (quad_mod && !cfg_q[`VEC_BIT_ACC_N])
            begin
              st_q       <= ST_WAIT_HI;
              timer_q    <= 32'h0;
              temp_ext_q <= (proto_q == `VEC_PROTO_QUAD);
            end
            else
            begin
              op_start_q <= 1'b1;
              op_fast_q  <= 1'b0;
            end
          end
        end
        ST_WAIT_HI:
        begin
          timer_q <= timer_q + 32'h1;
          if (vpp_lvl)
          begin
            op_start_q <= 1'b1;
            op_fast_q  <= 1'b1;
            st_q       <= temp_ext_q ? ST_WAIT_LO : ST_IDLE;
          end
          else if (timer_q == (TIMEOUT_CYC - 32'h1))
          begin
            // Set after any clear in this cycle, so the error is never lost
            op_start_q <= 1'b1;
            op_fast_q  <= 1'b0;
            vpp_err_q  <= 1'b1;
            temp_ext_q <= 1'b0;
            st_q       <= ST_IDLE;
          end
        end
        ST_WAIT_LO:
        begin
          // Quad protocol returns only once the accelerator falls back
          if (!vpp_lvl)
          begin
            temp_ext_q <= 1'b0;
            st_q       <= ST_IDLE;
          end
        end
        default:
        begin
          st_q       <= ST_IDLE;
          temp_ext_q <= 1'b0;
        end
      endcase
    end
  end

  assign cfg_o         = cfg_q;
  assign protocol_o    = proto_q;
  assign hold_en_o     = hold_en_q;
  assign drive_code_o  = drive_q;
  assign drive_valid_o = drive_valid_q;
  assign acc_enable_o  = acc_en_q;
  assign temp_ext_o    = temp_ext_q;
  assign vpp_err_o     = vpp_err_q;
  assign op_start_o    = op_start_q;
  assign op_fast_o     = op_fast_q;
  assign suspend_o     = suspend_q;
  assign dq_o          = dq_q;
  assign dq_oe_o       = dq_oe_q;

endmodule

// ==== testbench/vec_cfg_chk.sv ====
// Port assertions for the enhanced volatile configuration block
`timescale 1ns/1ps
`include "vec_cfg_defines.vh"
module vec_cfg_chk #(
  parameter [31:0] TIMEOUT_CYC = 900
) (
  input wire       core_clk_i,
  input wire       rstn_i,
  input wire       cs_n_i,
  input wire [7:0] cfg_o,
  input wire [1:0] protocol_o,
  input wire       hold_en_o,
  input wire [2:0] drive_code_o,
  input wire       drive_valid_o,
  input wire       acc_enable_o,
  input wire       temp_ext_o,
  input wire       vpp_err_o,
  input wire       op_start_o,
  input wire       op_fast_o
);
  // Margin is spare; the wait counter starts on the same edge that raises temp_ext_o
  localparam int TMO_MAX = TIMEOUT_CYC + 20;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  proto_sel_a: assert property (1 |=> protocol_o == ($past(temp_ext_o) ? `VEC_PROTO_EXT :
    !$past(cfg_o[7]) ? `VEC_PROTO_QUAD : !$past(cfg_o[6]) ? `VEC_PROTO_DUAL : `VEC_PROTO_EXT))
    else $error("protocol mismatch");
  hold_map_a: assert property (1 |=> hold_en_o == $past(cfg_o[4])) else $error("hold mismatch");
  acc_map_a: assert property (1 |=> acc_enable_o == !$past(cfg_o[3])) else $error("acc mismatch");
  drive_map_a: assert property (1 |=> drive_code_o == $past(cfg_o[2:0])
    && drive_valid_o == ($past(cfg_o[1:0]) != 2'h0)) else $error("drive mismatch");
  rsvd_zero_a: assert property (cfg_o[5] == 1'b0) else $error("bit 5 set");
  fast_acc_a: assert property (op_start_o && op_fast_o |-> acc_enable_o) else $error("fast without enable");
  temp_quad_a: assert property ($rose(temp_ext_o) |-> protocol_o == `VEC_PROTO_QUAD) else $error("temp ext");
  tmo_bound_a: assert property ($rose(temp_ext_o) |-> ##[1:TMO_MAX] op_start_o) else $error("no start");
  err_start_a: assert property ($rose(vpp_err_o) |-> op_start_o || $past(op_start_o)) else $error("err");
  err_clear_a: assert property ($fell(vpp_err_o) |-> !cs_n_i) else $error("flag dropped unselected");
endmodule
bind vec_config_core vec_cfg_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_vec_cfg_chk (.core_clk_i, .rstn_i, .cs_n_i,
  .cfg_o, .protocol_o, .hold_en_o, .drive_code_o, .drive_valid_o, .acc_enable_o, .temp_ext_o, .vpp_err_o,
  .op_start_o, .op_fast_o);

// ==== testbench/vec_spi_host.sv ====
// Behavioural serial host, mode 0, clock still between frames
`timescale 1ns/1ps
module vec_spi_host (
  // Answer lines
  input  wire  [3:0] dev_dq_i,
  // Serial bus
  output logic       spi_clk_o,
  output logic       cs_n_o,
  output logic [3:0] dq_o
);
  logic hold_lvl = 1'b1;
  initial
  begin
    spi_clk_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'hF;
  end
  task automatic open_frame();
    #3 cs_n_o = 1'b0;
    #80;
  endtask
  task automatic send(input logic [7:0] b, input int bpc);
    logic [7:0] m;
    for (int i = 8 - bpc; i >= 0; i -= bpc)
    begin
      m = b >> i;
      dq_o = (bpc == 4) ? m[3:0] : (bpc == 2) ? {hold_lvl, 1'b1, m[1:0]} : {hold_lvl, 2'h3, m[0]};
      #80 spi_clk_o = 1'b1;
      #80 spi_clk_o = 1'b0;
    end
  endtask
  task automatic recv(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      #80 b = {b[6:0], dev_dq_i[1]};
      spi_clk_o = 1'b1;
      #80 spi_clk_o = 1'b0;
    end
  endtask
  // Released lines show the inverse, so a stale copy cannot pass
  task automatic close_frame();
    #80 cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #797;
  endtask
endmodule

// ==== testbench/vec_config_core_bench.sv ====
// Self-checking bench for the enhanced volatile configuration block
`timescale 1ns/1ps
`include "vec_cfg_defines.vh"
module vec_config_core_bench;
  localparam int TMO = 900;
  localparam logic [7:0] WR = 8'hA1, RDC = 8'hA5, RDF = 8'hA7, CLR = 8'hA9, PP = 8'hB2, ER = 8'hC0, SUS = 8'hC5;
  localparam logic [7:0] FPQ = 8'hB3, FPQX = 8'hB4;
  logic       core_clk_i = 1'b0, rstn_i = 1'b0, vpp_high_i = 1'b0;
  logic       nv_quad_n_i = 1'b1, nv_dual_n_i = 1'b1, nv_hold_en_i = 1'b1;
  logic [2:0] nv_drive_i = 3'h5;
  wire        spi_clk_i, cs_n_i, hold_en_o, drive_valid_o, acc_enable_o;
  wire        temp_ext_o, vpp_err_o, op_start_o, op_fast_o, suspend_o;
  wire  [3:0] dq_i, dq_o, dq_oe_o;
  wire  [7:0] cfg_o;
  wire  [1:0] protocol_o;
  wire  [2:0] drive_code_o;
  int         fail_count = 0, comparisons = 0, starts = 0, susp = 0;
  logic       fast_q;
  logic [7:0] rd;
  vec_config_core #(.TIMEOUT_CYC(TMO)) u_vec_config_core (.core_clk_i, .rstn_i, .spi_clk_i, .cs_n_i, .dq_i,
    .dq_o, .dq_oe_o, .vpp_high_i, .nv_quad_n_i, .nv_dual_n_i, .nv_hold_en_i, .nv_drive_i, .cfg_o, .protocol_o,
    .hold_en_o, .drive_code_o, .drive_valid_o, .acc_enable_o, .temp_ext_o, .vpp_err_o, .op_start_o, .op_fast_o,
    .suspend_o);
  vec_spi_host u_vec_spi_host (.dev_dq_i(dq_o), .spi_clk_o(spi_clk_i), .cs_n_o(cs_n_i), .dq_o(dq_i));
  initial
  forever #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    if (op_start_o)
    begin
      starts++;
      fast_q = op_fast_o;
    end
    if (suspend_o)
      susp++;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Opcode, then n-1 copies of the data byte
  task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n, input int bpc);
    u_vec_spi_host.open_frame();
    u_vec_spi_host.send(op, bpc);
    for (int i = 1; i < n; i++)
      u_vec_spi_host.send(d, bpc);
    u_vec_spi_host.close_frame();
  endtask
  task automatic rdreg(input logic [7:0] op, output logic [7:0] v);
    u_vec_spi_host.open_frame();
    u_vec_spi_host.send(op, 1);
    u_vec_spi_host.recv(v);
    chk("oe on", dq_oe_o, `VEC_OE_EXT);
    u_vec_spi_host.close_frame();
    chk("oe off", dq_oe_o, `VEC_OE_NONE);
  endtask
  task automatic wait_start(input int n0);
    for (int i = 0; i < 2000 && starts == n0; i++)
      @(negedge core_clk_i);
    if (starts == n0)
    begin
      fail_count++;
      close_out();
    end
  endtask
  initial
  begin
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (10) @(negedge core_clk_i);
    chk("cfg", cfg_o, 8'hDD);
    chk("proto", protocol_o, `VEC_PROTO_EXT);
    rdreg(RDC, rd);
    chk("read cfg", rd, 8'hDD);
    u_vec_spi_host.hold_lvl = 1'b0;
    frame(WR, 8'h00, 2, 1);
    chk("held cfg", cfg_o, 8'hDD);
    u_vec_spi_host.hold_lvl = 1'b1;
    frame(WR, 8'hEF, 2, 1);
    chk("cfg", cfg_o, 8'hCF);
    chk("hold", hold_en_o, 1'b0);
    u_vec_spi_host.hold_lvl = 1'b0;
    frame(WR, 8'hBF, 2, 1);
    chk("proto", protocol_o, `VEC_PROTO_DUAL);
    chk("hold", hold_en_o, 1'b1);
    u_vec_spi_host.hold_lvl = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      frame(WR, 8'h98 | c[7:0], 2, 2);
      chk("drive", drive_code_o, c[2:0]);
      chk("valid", drive_valid_o, c[1:0] != 2'h0);
    end
    frame(WR, 8'h17, 2, 2);
    chk("proto", protocol_o, `VEC_PROTO_QUAD);
    chk("acc", acc_enable_o, 1'b1);
    frame(ER, 8'h00, 4, 4);
    chk("temp", temp_ext_o, 1'b1);
    rdreg(RDF, rd);
    chk("flag", rd & 8'h88, 8'h00);
    wait_start(0);
    chk("fast", fast_q, 1'b0);
    @(negedge core_clk_i);
    chk("err", vpp_err_o, 1'b1);
    frame(CLR, 8'h00, 1, 4);
    chk("err", vpp_err_o, 1'b0);
    frame(ER, 8'h00, 4, 4);
    frame(SUS, 8'h00, 1, 1);
    chk("suspend", susp[7:0], 8'h01);
    @(negedge core_clk_i);
    vpp_high_i = 1'b1;
    wait_start(1);
    chk("fast", fast_q, 1'b1);
    @(negedge core_clk_i);
    vpp_high_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    chk("temp", temp_ext_o, 1'b0);
    chk("err", vpp_err_o, 1'b0);
    frame(WR, 8'h97, 2, 4);
    chk("proto", protocol_o, `VEC_PROTO_DUAL);
    frame(PP, 8'h3C, 5, 2);
    chk("starts", starts[7:0], 8'h03);
    chk("fast", fast_q, 1'b0);
    chk("temp", temp_ext_o, 1'b0);
    // Four-input program in extended protocol waits for the accelerator without a protocol change
    frame(WR, 8'hD7, 2, 2);
    frame(FPQ, 8'h5A, 5, 1);
    chk("temp", temp_ext_o, 1'b0);
    chk("starts", starts[7:0], 8'h03);
    @(negedge core_clk_i);
    vpp_high_i = 1'b1;
    wait_start(3);
    chk("fast", fast_q, 1'b1);
    @(negedge core_clk_i);
    vpp_high_i = 1'b0;
    frame(WR, 8'hDF, 2, 1);
    frame(FPQX, 8'h5A, 5, 1);
    chk("starts", starts[7:0], 8'h05);
    chk("fast", fast_q, 1'b0);
    rstn_i = 1'b0;
    nv_hold_en_i = 1'b0;
    nv_dual_n_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (10) @(negedge core_clk_i);
    chk("cfg", cfg_o, 8'h8D);
    chk("hold", hold_en_o, 1'b0);
    close_out();
  end
endmodule
